/* hspc_pkg.sv */
// constants for the status and parameter command interpreter
package hspc_pkg;
   // report framing
   localparam int REPORT_LEN = 64;
   localparam logic [5:0] LAST_IDX = 6'h3F;
   // command and sub-command codes
   localparam logic [7:0] CMD_STATUS = 8'h10;
   localparam logic [7:0] CANCEL_CODE = 8'h10;
   localparam logic [7:0] SPEED_CODE = 8'h20;
   // outcome codes
   localparam logic [7:0] RES_NONE = 8'h00;
   localparam logic [7:0] RES_OK = 8'h00;
   localparam logic [7:0] CANCEL_MARKED = 8'h10;
   localparam logic [7:0] CANCEL_IDLE = 8'h11;
   localparam logic [7:0] SPEED_TAKEN = 8'h20;
   localparam logic [7:0] SPEED_REFUSED = 8'h21;
   // request byte positions
   localparam logic [5:0] RQ_CMD = 6'h00;
   localparam logic [5:0] RQ_CANCEL = 6'h02;
   localparam logic [5:0] RQ_SPEED = 6'h03;
   localparam logic [5:0] RQ_DIV = 6'h04;
   // response byte positions
   localparam logic [5:0] RS_CMD = 6'h00;
   localparam logic [5:0] RS_STAT = 6'h01;
   localparam logic [5:0] RS_CANCEL = 6'h02;
   localparam logic [5:0] RS_SPEED = 6'h03;
   localparam logic [5:0] RS_DIV = 6'h04;
   localparam logic [5:0] RS_LEN_LO = 6'h09;
   localparam logic [5:0] RS_LEN_HI = 6'h0A;
   localparam logic [5:0] RS_DONE_LO = 6'h0B;
   localparam logic [5:0] RS_DONE_HI = 6'h0C;
   localparam logic [5:0] RS_BUF = 6'h0D;
   localparam logic [5:0] RS_CUR_DIV = 6'h0E;
   localparam logic [5:0] RS_TMO = 6'h0F;
   localparam logic [5:0] RS_ADR_LO = 6'h10;
   localparam logic [5:0] RS_ADR_HI = 6'h11;
   localparam logic [5:0] RS_SCL = 6'h16;
   localparam logic [5:0] RS_SDA = 6'h17;
   localparam logic [5:0] RS_EDGE = 6'h18;
   localparam logic [5:0] RS_RDPEND = 6'h19;
   localparam logic [5:0] RS_HW_MAJ = 6'h2E;
   localparam logic [5:0] RS_HW_MIN = 6'h2F;
   localparam logic [5:0] RS_FW_MAJ = 6'h30;
   localparam logic [5:0] RS_FW_MIN = 6'h31;
   localparam logic [5:0] RS_ADC0_LO = 6'h32;
   localparam logic [5:0] RS_ADC0_HI = 6'h33;
   localparam logic [5:0] RS_ADC1_LO = 6'h34;
   localparam logic [5:0] RS_ADC1_HI = 6'h35;
   localparam logic [5:0] RS_ADC2_LO = 6'h36;
   localparam logic [5:0] RS_ADC2_HI = 6'h37;
   // reset values
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // interpreter states, one-hot
   typedef enum logic [2:0] {
      ST_RX = 3'b001,
      ST_EVAL = 3'b010,
      ST_TX = 3'b100
   } hspc_state_t;
endpackage

/* hspc_rsp_mux.sv */
// response byte selector: maps a report index to its byte
`timescale 1ns/1ns
module hspc_rsp_mux (
   input wire logic [5:0] idx,
   input wire logic [7:0] cancel_res,
   input wire logic [7:0] speed_res,
   input wire logic [7:0] div_echo,
   input wire logic [15:0] xfer_len,
   input wire logic [15:0] xfer_done,
   input wire logic [7:0] buf_cnt,
   input wire logic [7:0] cur_div,
   input wire logic [7:0] cur_timeout,
   input wire logic [15:0] tgt_addr,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic edge_state,
   input wire logic [1:0] read_pend,
   input wire logic [31:0] rev_bytes,
   input wire logic [15:0] adc0,
   input wire logic [15:0] adc1,
   input wire logic [15:0] adc2,
   output logic [7:0] byte_out
);
   // one byte per index; unlisted indices read zero
   always_comb begin
      byte_out = 8'h00;
      unique case (idx)
         hspc_pkg::RS_CMD: byte_out = hspc_pkg::CMD_STATUS;
         hspc_pkg::RS_STAT: byte_out = hspc_pkg::RES_OK;
         hspc_pkg::RS_CANCEL: byte_out = cancel_res;
         hspc_pkg::RS_SPEED: byte_out = speed_res;
         hspc_pkg::RS_DIV: byte_out = div_echo;
         hspc_pkg::RS_LEN_LO: byte_out = xfer_len[7:0];
         hspc_pkg::RS_LEN_HI: byte_out = xfer_len[15:8];
         hspc_pkg::RS_DONE_LO: byte_out = xfer_done[7:0];
         hspc_pkg::RS_DONE_HI: byte_out = xfer_done[15:8];
         hspc_pkg::RS_BUF: byte_out = buf_cnt;
         hspc_pkg::RS_CUR_DIV: byte_out = cur_div;
         hspc_pkg::RS_TMO: byte_out = cur_timeout;
         hspc_pkg::RS_ADR_LO: byte_out = tgt_addr[7:0];
         hspc_pkg::RS_ADR_HI: byte_out = tgt_addr[15:8];
         hspc_pkg::RS_SCL: byte_out = {7'h00, scl_in};
         hspc_pkg::RS_SDA: byte_out = {7'h00, sda_in};
         hspc_pkg::RS_EDGE: byte_out = {7'h00, edge_state};
         hspc_pkg::RS_RDPEND: byte_out = {6'h00, read_pend};
         hspc_pkg::RS_HW_MAJ: byte_out = rev_bytes[31:24];
         hspc_pkg::RS_HW_MIN: byte_out = rev_bytes[23:16];
         hspc_pkg::RS_FW_MAJ: byte_out = rev_bytes[15:8];
         hspc_pkg::RS_FW_MIN: byte_out = rev_bytes[7:0];
         hspc_pkg::RS_ADC0_LO: byte_out = adc0[7:0];
         hspc_pkg::RS_ADC0_HI: byte_out = adc0[15:8];
         hspc_pkg::RS_ADC1_LO: byte_out = adc1[7:0];
         hspc_pkg::RS_ADC1_HI: byte_out = adc1[15:8];
         hspc_pkg::RS_ADC2_LO: byte_out = adc2[7:0];
         hspc_pkg::RS_ADC2_HI: byte_out = adc2[15:8];
         default: byte_out = 8'h00;
      endcase
   end
endmodule

/* hspc_status_cmd.sv */
// status and parameter command interpreter for 64-byte reports
`timescale 1ns/1ns
module hspc_status_cmd #(
   parameter logic [7:0] HW_REV_MAJ = 8'h48, // arbitrary value
   parameter logic [7:0] HW_REV_MIN = 8'h30, // arbitrary value
   parameter logic [7:0] FW_REV_MAJ = 8'h32, // arbitrary value
   parameter logic [7:0] FW_REV_MIN = 8'h33 // arbitrary value
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [7:0] req_data,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [7:0] rsp_data,
   output logic rsp_last,
   input wire logic engine_busy,
   output logic cancel_pulse,
   output logic div_load,
   output logic [7:0] div_value,
   input wire logic [15:0] xfer_len,
   input wire logic [15:0] xfer_done,
   input wire logic [7:0] buf_cnt,
   input wire logic [7:0] cur_div,
   input wire logic [7:0] cur_timeout,
   input wire logic [15:0] tgt_addr,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic edge_state,
   input wire logic [1:0] read_pend,
   input wire logic [15:0] adc0,
   input wire logic [15:0] adc1,
   input wire logic [15:0] adc2,
   input wire logic [7:0] nv_chip_cfg,
   input wire logic nv_sn_enable,
   output logic [7:0] vol_chip_cfg,
   output logic sn_present
);
   // ****************************************
   // state and storage
   // ****************************************
   hspc_pkg::hspc_state_t state_r;
   logic [5:0] rx_idx_r;
   logic [5:0] tx_idx_r;
   logic [7:0] req_cmd_r;
   logic [7:0] req_cancel_r;
   logic [7:0] req_speed_r;
   logic [7:0] req_div_r;
   logic [7:0] cancel_res_r;
   logic [7:0] speed_res_r;
   logic [7:0] div_echo_r;
   logic rsp_valid_r;
   logic [7:0] rsp_data_r;
   logic cancel_pulse_r;
   logic div_load_r;
   logic [7:0] div_value_r;
   logic [7:0] vol_cfg_r;
   logic cfg_loaded_r;
   logic [5:0] mux_idx;
   logic [7:0] mux_byte;
   logic rx_take;
   logic tx_take;

   // handshakes; the receiver is shut while a reply is pending
   assign req_ready = (state_r == hspc_pkg::ST_RX);
   assign rx_take = req_valid && req_ready;
   assign tx_take = rsp_valid_r && rsp_ready;
   assign rsp_valid = rsp_valid_r;
   assign rsp_data = rsp_data_r;
   assign rsp_last = rsp_valid_r && (tx_idx_r == hspc_pkg::LAST_IDX);
   assign cancel_pulse = cancel_pulse_r;
   assign div_load = div_load_r;
   assign div_value = div_value_r;
   assign vol_chip_cfg = vol_cfg_r;

   // ****************************************
   // request intake
   // ****************************************
   // fixed report length
   // a 6-bit index wraps at 64, so framing cannot drift between reports
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_idx_r <= 6'h00;
      end else if (rx_take) begin
         rx_idx_r <= rx_idx_r + 6'h01;
      end
   end

   // only bytes 0, 2, 3, 4 are kept
   // the remaining request bytes are dropped
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         req_cmd_r <= 8'h00;
         req_cancel_r <= 8'h00;
         req_speed_r <= 8'h00;
         req_div_r <= 8'h00;
      end else if (rx_take) begin
         if (rx_idx_r == hspc_pkg::RQ_CMD) begin
            req_cmd_r <= req_data;
         end
         if (rx_idx_r == hspc_pkg::RQ_CANCEL) begin
            req_cancel_r <= req_data;
         end
         if (rx_idx_r == hspc_pkg::RQ_SPEED) begin
            req_speed_r <= req_data;
         end
         if (rx_idx_r == hspc_pkg::RQ_DIV) begin
            req_div_r <= req_data;
         end
      end
   end

   // ****************************************
   // sequencing
   // ****************************************
   // one reply per request
   // reports with another command code are left to other interpreters
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r <= hspc_pkg::ST_RX;
      end else begin
         unique case (state_r)
            hspc_pkg::ST_RX: begin
               if (rx_take && rx_idx_r == hspc_pkg::LAST_IDX && req_cmd_r == hspc_pkg::CMD_STATUS) begin
                  state_r <= hspc_pkg::ST_EVAL;
               end
            end
            hspc_pkg::ST_EVAL: begin
               state_r <= hspc_pkg::ST_TX;
            end
            hspc_pkg::ST_TX: begin
               if (tx_take && tx_idx_r == hspc_pkg::LAST_IDX) begin
                  state_r <= hspc_pkg::ST_RX;
               end
            end
         endcase
      end
   end

   // ****************************************
   // sub-command evaluation
   // ****************************************
   // cancel decision, one evaluation per report
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cancel_res_r <= hspc_pkg::RES_NONE;
         cancel_pulse_r <= 1'b0;
      end else if (state_r == hspc_pkg::ST_EVAL) begin
         if (req_cancel_r != hspc_pkg::CANCEL_CODE) begin
            cancel_res_r <= hspc_pkg::RES_NONE;
            cancel_pulse_r <= 1'b0;
         end else if (engine_busy) begin
            cancel_res_r <= hspc_pkg::CANCEL_MARKED;
            cancel_pulse_r <= 1'b1;
         end else begin
            cancel_res_r <= hspc_pkg::CANCEL_IDLE;
            cancel_pulse_r <= 1'b0;
         end
      end else begin
         cancel_pulse_r <= 1'b0;
      end
   end

   // divider load, refused while the engine is busy
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         speed_res_r <= hspc_pkg::RES_NONE;
         div_echo_r <= 8'h00;
         div_load_r <= 1'b0;
      end else if (state_r == hspc_pkg::ST_EVAL) begin
         if (req_speed_r != hspc_pkg::SPEED_CODE) begin
            speed_res_r <= hspc_pkg::RES_NONE;
            div_echo_r <= 8'h00;
            div_load_r <= 1'b0;
         end else if (engine_busy) begin
            speed_res_r <= hspc_pkg::SPEED_REFUSED;
            div_echo_r <= req_div_r;
            div_load_r <= 1'b0;
         end else begin
            speed_res_r <= hspc_pkg::SPEED_TAKEN;
            div_echo_r <= req_div_r;
            div_load_r <= 1'b1;
         end
      end else begin
         div_load_r <= 1'b0;
      end
   end

   // divider handed to the engine, which bounds the bit rate
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_value_r <= hspc_pkg::DIV_RESET;
      end else if (state_r == hspc_pkg::ST_EVAL && req_speed_r == hspc_pkg::SPEED_CODE && !engine_busy) begin
         div_value_r <= req_div_r;
      end
   end

   // ****************************************
   // response output
   // ****************************************
   // next byte to present: index 0 on entry, else the one after the taken byte
   assign mux_idx = (state_r == hspc_pkg::ST_EVAL) ? hspc_pkg::RS_CMD : tx_idx_r + 6'h01;
   // 16-bit length and count fields cover 65,535-byte transfers
   hspc_rsp_mux u_mux (
      .idx(mux_idx),
      .cancel_res(cancel_res_r),
      .speed_res(speed_res_r),
      .div_echo(div_echo_r),
      .xfer_len(xfer_len),
      .xfer_done(xfer_done),
      .buf_cnt(buf_cnt),
      .cur_div(cur_div),
      .cur_timeout(cur_timeout),
      .tgt_addr(tgt_addr),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .edge_state(edge_state),
      .read_pend(read_pend),
      .rev_bytes({HW_REV_MAJ, HW_REV_MIN, FW_REV_MAJ, FW_REV_MIN}),
      .adc0(adc0),
      .adc1(adc1),
      .adc2(adc2),
      .byte_out(mux_byte)
   );

   // exactly 64 bytes go out, then valid drops
   // live status is sampled as each byte is loaded, when the byte before it is taken, and is held while the host stalls
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rsp_valid_r <= 1'b0;
         rsp_data_r <= 8'h00;
         tx_idx_r <= 6'h00;
      end else if (state_r == hspc_pkg::ST_EVAL) begin
         rsp_valid_r <= 1'b1;
         rsp_data_r <= mux_byte;
         tx_idx_r <= 6'h00;
      end else if (tx_take) begin
         if (tx_idx_r == hspc_pkg::LAST_IDX) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 8'h00;
            tx_idx_r <= 6'h00;
         end else begin
            rsp_data_r <= mux_byte;
            tx_idx_r <= mux_idx;
         end
      end
   end

   // ****************************************
   // settings copy
   // ****************************************
   // chip settings copied once after reset; USB settings are not
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         vol_cfg_r <= hspc_pkg::CFG_RESET;
         cfg_loaded_r <= 1'b0;
      end else if (!cfg_loaded_r) begin
         vol_cfg_r <= nv_chip_cfg;
         cfg_loaded_r <= 1'b1;
      end
   end

   // serial-number presence follows the nonvolatile enable directly
   assign sn_present = nv_sn_enable;

   // ****************************************
   // checks
   // ****************************************
   report_end_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (tx_take && tx_idx_r == hspc_pkg::LAST_IDX) |=> !rsp_valid_r && state_r == hspc_pkg::ST_RX)
      else $error("response did not end after 64 bytes");
   rx_closed_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      rsp_valid_r |-> !req_ready)
      else $error("request accepted while a response is pending");
   code_echo_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      state_r == hspc_pkg::ST_EVAL |=> rsp_valid_r && rsp_data_r == hspc_pkg::CMD_STATUS && tx_idx_r == 6'h00)
      else $error("command code not echoed first");
   cancel_cause_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      cancel_pulse_r |-> $past(state_r) == hspc_pkg::ST_EVAL && req_cancel_r == hspc_pkg::CANCEL_CODE
      && cancel_res_r == hspc_pkg::CANCEL_MARKED)
      else $error("cancel issued without a cancel request");
   cancel_idle_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (state_r == hspc_pkg::ST_EVAL && req_cancel_r == hspc_pkg::CANCEL_CODE && !engine_busy)
      |=> cancel_res_r == hspc_pkg::CANCEL_IDLE && !cancel_pulse_r)
      else $error("idle cancel outcome wrong");
   div_take_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      div_load_r |-> div_value_r == req_div_r && req_speed_r == hspc_pkg::SPEED_CODE)
      else $error("divider loaded without a speed request");
   speed_refuse_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (state_r == hspc_pkg::ST_EVAL && req_speed_r == hspc_pkg::SPEED_CODE && engine_busy)
      |=> speed_res_r == hspc_pkg::SPEED_REFUSED && !div_load_r && $stable(div_value_r))
      else $error("busy engine did not refuse the divider");
   div_echo_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (state_r == hspc_pkg::ST_EVAL && req_speed_r != hspc_pkg::SPEED_CODE)
      |=> div_echo_r == 8'h00 && speed_res_r == hspc_pkg::RES_NONE)
      else $error("divider echo not zero without speed request");
   div_ignore_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (state_r == hspc_pkg::ST_EVAL && req_speed_r != hspc_pkg::SPEED_CODE) |=> $stable(div_value_r))
      else $error("divider changed without speed request");
endmodule

/* hspc_host_model.sv */
// host-side model: writes request reports and reads the replies
`timescale 1ns/1ns
module hspc_host_model (
   input wire logic mclk,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_last,
   output logic req_valid,
   output logic [7:0] req_data,
   output logic rsp_ready
);
   integer seed = 32'hA5F1C316;
   logic [7:0] rq [64];
   logic [7:0] rs [64];
   logic [63:0] lastv;

   // idle lines at time zero
   initial begin
      req_valid = 1'b0;
      req_data = 8'h00;
      rsp_ready = 1'b0;
   end

   task automatic send(input bit slow);
      for (int i = 0; i < 64; i++) begin
         // gaps show a changing pattern, never a stale byte
         while (slow && ($random(seed) % 3) == 0) begin
            req_valid <= 1'b0;
            req_data <= ~req_data;
            @(posedge mclk);
         end
         req_valid <= 1'b1;
         req_data <= rq[i];
         do @(posedge mclk); while (req_ready !== 1'b1);
      end
      req_valid <= 1'b0;
      req_data <= ~rq[63];
   endtask

   task automatic fetch(input bit slow);
      int n;
      n = 0;
      while (n < 64) begin
         rsp_ready <= slow ? 1'($random(seed)) : 1'b1;
         @(posedge mclk);
         if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            rs[n] = rsp_data;
            lastv[n] = rsp_last;
            n++;
         end
      end
      rsp_ready <= 1'b0;
   endtask
endmodule

/* hspc_status_cmd_bench.sv */
// self-checking bench for the status and parameter command interpreter
`timescale 1ns/1ns
module hspc_status_cmd_bench;
   // arbitrary revision values
   localparam logic [7:0] HMA = 8'h52;
   localparam logic [7:0] HMI = 8'h53;
   localparam logic [7:0] FMA = 8'h54;
   localparam logic [7:0] FMI = 8'h55;
   logic mclk, rst_n, req_valid, req_ready, rsp_valid, rsp_ready, rsp_last;
   logic engine_busy, cancel_pulse, div_load, scl_in, sda_in, edge_state, nv_sn_enable, sn_present;
   logic [7:0] req_data, rsp_data, div_value, buf_cnt, cur_div, cur_timeout, nv_chip_cfg, vol_chip_cfg;
   logic [15:0] xfer_len, xfer_done, tgt_addr, adc0, adc1, adc2;
   logic [1:0] read_pend;
   integer seed = 32'hA5F1C316;
   int bad_count = 0;
   int num_checks = 0;
   // pulse counters run free; each exchange compares against a snapshot
   int n_can = 0;
   int n_div = 0;
   int can0, div0;

   hspc_status_cmd #(.HW_REV_MAJ(HMA), .HW_REV_MIN(HMI), .FW_REV_MAJ(FMA), .FW_REV_MIN(FMI))
   hspc_status_cmd_i (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req_data(req_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data),
      .rsp_last(rsp_last), .engine_busy(engine_busy), .cancel_pulse(cancel_pulse), .div_load(div_load),
      .div_value(div_value), .xfer_len(xfer_len), .xfer_done(xfer_done), .buf_cnt(buf_cnt),
      .cur_div(cur_div), .cur_timeout(cur_timeout), .tgt_addr(tgt_addr), .scl_in(scl_in),
      .sda_in(sda_in), .edge_state(edge_state), .read_pend(read_pend), .adc0(adc0), .adc1(adc1),
      .adc2(adc2), .nv_chip_cfg(nv_chip_cfg), .nv_sn_enable(nv_sn_enable),
      .vol_chip_cfg(vol_chip_cfg), .sn_present(sn_present));

   hspc_host_model host_i (.mclk(mclk), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_last(rsp_last), .req_valid(req_valid), .req_data(req_data),
      .rsp_ready(rsp_ready));

   // ****************
   // helpers
   // ****************
   // free-running clock, 8 ns period
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // count control pulses over the whole run
   always @(posedge mclk) begin
      if (cancel_pulse === 1'b1) n_can++;
      if (div_load === 1'b1) n_div++;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // status inputs stay put for a whole exchange since bytes sample them late
   task automatic shake(input logic b);
      engine_busy <= b;
      xfer_len <= 16'($random(seed));
      xfer_done <= 16'($random(seed));
      buf_cnt <= 8'($random(seed));
      cur_div <= 8'($random(seed));
      cur_timeout <= 8'($random(seed));
      tgt_addr <= 16'($random(seed));
      {scl_in, sda_in, edge_state} <= 3'($random(seed));
      read_pend <= 2'(($random(seed) & 32'h7FFF) % 3);
      adc0 <= 16'($random(seed));
      adc1 <= 16'($random(seed));
      adc2 <= 16'($random(seed));
   endtask

   function automatic logic [7:0] expb(int i);
      logic [7:0] b2, b3;
      b2 = host_i.rq[2];
      b3 = host_i.rq[3];
      case (i)
         0: return 8'h10;
         2: return b2 != 8'h10 ? 8'h00 : engine_busy ? 8'h10 : 8'h11;
         3: return b3 != 8'h20 ? 8'h00 : engine_busy ? 8'h21 : 8'h20;
         4: return b3 == 8'h20 ? host_i.rq[4] : 8'h00;
         9: return xfer_len[7:0];
         10: return xfer_len[15:8];
         11: return xfer_done[7:0];
         12: return xfer_done[15:8];
         13: return buf_cnt;
         14: return cur_div;
         15: return cur_timeout;
         16: return tgt_addr[7:0];
         17: return tgt_addr[15:8];
         22: return {7'h00, scl_in};
         23: return {7'h00, sda_in};
         24: return {7'h00, edge_state};
         25: return {6'h00, read_pend};
         46: return HMA;
         47: return HMI;
         48: return FMA;
         49: return FMI;
         50: return adc0[7:0];
         51: return adc0[15:8];
         52: return adc1[7:0];
         53: return adc1[15:8];
         54: return adc2[7:0];
         55: return adc2[15:8];
         default: return 8'h00;
      endcase
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // watchdog: 24 exchanges, some stalled, need well under a fifth of this
   initial begin
      #400000;
      bad_count++;
      $display("wrong value at %0t: run hung", $time);
      test_done();
   end

   // ****************
   // test sequence
   // ****************
   initial begin
      logic [7:0] dv;
      rst_n = 1'b0;
      nv_chip_cfg = 8'h5A;
      nv_sn_enable = 1'b0;
      shake(1'b0);
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      #1;
      chk(vol_chip_cfg, 8'h5A, "volatile copy");
      chk(div_value, 8'h00, "divider at reset");
      chk({7'h00, sn_present}, 8'h00, "serial hidden");
      @(posedge mclk);
      nv_sn_enable <= 1'b1;
      nv_chip_cfg <= 8'hC3;
      repeat (3) @(posedge mclk);
      chk({7'h00, sn_present}, 8'h01, "serial shown");
      chk(vol_chip_cfg, 8'h5A, "copy taken once");
      $display("test reset done");
      // foreign command code gets no reply
      for (int i = 0; i < 64; i++) host_i.rq[i] = 8'($random(seed));
      host_i.rq[0] = 8'h55;
      host_i.send(1'b0);
      repeat (10) @(posedge mclk);
      chk({6'h00, rsp_valid, req_ready}, 8'h01, "foreign code");
      $display("test foreign done");
      // first eight cover every code and busy pairing, the rest are random
      for (int t = 0; t < 24; t++) begin
         @(posedge mclk);
         shake(t < 8 ? t[2] : 1'($random(seed)));
         for (int i = 0; i < 64; i++) host_i.rq[i] = 8'($random(seed));
         host_i.rq[0] = 8'h10;
         if (t < 8) begin
            host_i.rq[2] = t[0] ? 8'h10 : 8'h11;
            host_i.rq[3] = t[1] ? 8'h20 : 8'h21;
         end else begin
            if ($random(seed) & 1) host_i.rq[2] = 8'h10;
            if ($random(seed) & 1) host_i.rq[3] = 8'h20;
         end
         can0 = n_can;
         div0 = n_div;
         dv = div_value;
         host_i.send(t[3]);
         host_i.fetch(t[0]);
         for (int i = 0; i < 64; i++) begin
            chk(host_i.rs[i], expb(i), $sformatf("reply byte %0d", i));
            chk({7'h00, host_i.lastv[i]}, {7'h00, i == 63}, "last flag");
         end
         chk(8'(n_can - can0), {7'h00, host_i.rq[2] == 8'h10 && engine_busy}, "cancel pulses");
         chk(8'(n_div - div0), {7'h00, host_i.rq[3] == 8'h20 && !engine_busy}, "load pulses");
         // expected divider from the request and busy level, not from the pulse count
         chk(div_value, (host_i.rq[3] == 8'h20 && !engine_busy) ? host_i.rq[4] : dv, "divider");
         @(posedge mclk);
         #1;
         chk({6'h00, rsp_valid, req_ready}, 8'h01, "ready for next");
         $display("test exchange %0d done", t);
      end
      test_done();
   end
endmodule
